// ==== rtl/gpc_pkg.sv ====
// Constants, types and helpers for the global pin and clock select block
package gpc_pkg;

  // ==========================================================================
  // Bus and register map
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;
  localparam logic [9:0]  IDX_PIN_INHIBIT = 10'h0F0;
  localparam logic [9:0]  IDX_PIN_FUNC    = 10'h0F1;
  localparam logic [9:0]  IDX_XCVR_TWO    = 10'h0F2;
  localparam logic [9:0]  IDX_CLK_SRC     = 10'h0F3;
  localparam logic [7:0]  RST_PIN_INHIBIT = 8'h00;
  localparam logic [7:0]  RST_PIN_FUNC    = 8'h00;
  localparam logic [7:0]  RST_XCVR_TWO    = 8'h00;
  localparam logic [7:0]  RST_CLK_SRC     = 8'h00;
  localparam logic [7:0]  MASK_PIN_INHIBIT = 8'h01;
  localparam logic [7:0]  MASK_PIN_FUNC    = 8'hFF;
  localparam logic [7:0]  MASK_XCVR_TWO    = 8'h06;
  localparam logic [7:0]  MASK_CLK_SRC     = 8'hFF;

  // ==========================================================================
  // Field positions
  localparam int BIT_PIN_INHIBIT = 0;
  localparam int LSB_IBUS_MODE   = 6;
  localparam int LSB_BP_RATE     = 4;
  localparam int BIT_ALARM_SEL   = 3;
  localparam int BIT_SYNC_SEL    = 2;
  localparam int BIT_TXCH_SEL    = 1;
  localparam int BIT_RXCH_SEL    = 0;
  localparam int BIT_LOSS_SRC    = 2;
  localparam int BIT_FS_DIR      = 1;
  localparam int LSB_REF_SRC     = 4;
  localparam int BIT_REF_RATE    = 3;
  localparam int BIT_MBASE       = 2;
  localparam int LSB_MMULT       = 0;

  // ==========================================================================
  // Reference source codes
  localparam logic [3:0] REF_SRC_LAST_CH = 4'h7;
  localparam logic [3:0] REF_SRC_MCLK_T1 = 4'h8;
  localparam logic [3:0] REF_SRC_MCLK_E1 = 4'h9;
  localparam logic [3:0] REF_SRC_PIN     = 4'hA;

  // ==========================================================================
  // Timing
  localparam longint CLK_HZ          = 20000000;
  localparam int     CLK_PERIOD_NS   = 50;
  localparam int     FRAME_PERIOD_NS = 125000;
  localparam int     FRAME_CYCLES    = FRAME_PERIOD_NS / CLK_PERIOD_NS;
  localparam int     FRAME_CNT_W     = 12;
  localparam longint REF_T1_HZ       = 1544000;
  localparam longint REF_E1_HZ       = 2048000;
  localparam int     NCO_W           = 24;
  localparam logic [NCO_W-1:0] NCO_INC_T1 = NCO_W'((REF_T1_HZ << NCO_W) / CLK_HZ);
  localparam logic [NCO_W-1:0] NCO_INC_E1 = NCO_W'((REF_E1_HZ << NCO_W) / CLK_HZ);

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {IBUS_OFF, IBUS_TWO, IBUS_FOUR, IBUS_EIGHT} gpc_ibus_mode_t;

  typedef struct packed {
    logic [7:0] rx_loss_framer;
    logic [7:0] rx_loss_line;
    logic [7:0] rx_sig_freeze;
    logic [7:0] rx_frame_sync;
    logic [7:0] rx_mframe_sync;
    logic [7:0] tx_chan_block;
    logic [7:0] tx_chan_clock;
    logic [7:0] rx_chan_block;
    logic [7:0] rx_chan_clock;
  } gpc_port_status_t;

  typedef struct packed {
    logic [7:0] shared_alarm_pin;
    logic [7:0] rx_sync_pin;
    logic [7:0] tx_channel_pin;
    logic [7:0] rx_channel_pin;
  } gpc_shared_pins_t;

  // Two-bit code to one-hot multiple: x1, x2, x4, x8
  function automatic logic [3:0] gpc_multiple(input logic [1:0] code);
    gpc_multiple = 4'h1 << code;
  endfunction : gpc_multiple

endpackage : gpc_pkg

// ==== rtl/gpc_global_ctrl.sv ====
// Global pin function, interleaved bus and clock source control bank
//
// How it works
// - Inhibit bit clear: interrupt pin low on pending interrupt; set: held high.
// - Interleaved bus mode: off, two, four or eight devices on the bus.
// - Backplane clock rate code picks 2.048, 4.096, 8.192 or 16.384 MHz.
// - Alarm pins show receive loss at 0, signaling freeze at 1.
// - Loss source bit picks line-interface loss when set, framer loss when clear.
// - Sync pins show frame sync at 0, multiframe sync at 1.
// - Transmit channel pins show channel block at 0, channel clock at 1.
// - Receive channel pins show channel block at 0, channel clock at 1.
// - Direction bit set: frame sync pin drives 8 kHz pulse; clear: input.
// - Reference rate bit declares backplane reference 2.048 MHz or 1.544 MHz.
// - Source codes 0 to 7 pick recovered clock of channel 1 to 8.
// - Code 8 with rate bit set and code 9 with rate bit clear derive reference from master clock, driving the pin out.
// - Code 10 makes reference pin an input fed externally at declared rate.
// - Master base rate bit declares 2.048 MHz or 1.544 MHz family.
// - Master period multiple code gives times one, two, four or eight.
`timescale 1ns/1ps

module gpc_global_ctrl
  import gpc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [DATA_W-1:0] wb_dat_i,
  output logic      [DATA_W-1:0] wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              irq_pending,
  output logic                   interrupt_out_n,
  input  wire gpc_port_status_t  port_status,
  output gpc_shared_pins_t       shared_pins,
  output gpc_ibus_mode_t         interleaved_bus_mode,
  output logic      [3:0]        interleaved_bus_rate,
  output logic      [3:0]        backplane_clock_rate,
  input  wire logic              tx_frame_sync_pin_i,
  output logic                   tx_frame_sync_pin_o,
  output logic                   tx_frame_sync_pin_oe,
  output logic                   frame_sync,
  input  wire logic [7:0]        recovered_clock,
  input  wire logic              reference_clock_pin_i,
  output logic                   reference_clock_pin_o,
  output logic                   reference_clock_pin_oe,
  output logic                   backplane_ref_clock,
  output logic                   backplane_ref_rate,
  output logic                   ref_config_valid,
  output logic                   master_base_rate,
  output logic      [3:0]        master_period_multiple
);

  // ==========================================================================
  // Registers
  logic [7:0]             inhibit_r;
  logic [7:0]             pin_func_r;
  logic [7:0]             xcvr_two_r;
  logic [7:0]             clk_src_r;
  logic [9:0]             idx;
  logic                   wr_go;
  logic [7:0]             rd_nxt;
  logic [FRAME_CNT_W-1:0] frame_cnt_r;
  logic [NCO_W-1:0]       nco_r;
  logic [3:0]             ref_src;
  logic                   ref_rate;
  logic                   ref_from_mclk;
  logic                   ref_nxt;

  assign idx   = wb_adr_i[ADDR_W-1:2];
  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  // ==========================================================================
  // Wishbone slave
  always_comb
  begin
    rd_nxt = 8'h00;
    unique case (idx)
      IDX_PIN_INHIBIT: rd_nxt = inhibit_r;
      IDX_PIN_FUNC:    rd_nxt = pin_func_r;
      IDX_XCVR_TWO:    rd_nxt = xcvr_two_r;
      IDX_CLK_SRC:     rd_nxt = clk_src_r;
      default:         rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= {24'h000000, rd_nxt};
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      inhibit_r  <= RST_PIN_INHIBIT;
      pin_func_r <= RST_PIN_FUNC;
      xcvr_two_r <= RST_XCVR_TWO;
      clk_src_r  <= RST_CLK_SRC;
    end
    else if (wr_go)
    begin
      if (idx == IDX_PIN_INHIBIT)
        inhibit_r <= wb_dat_i[7:0] & MASK_PIN_INHIBIT;
      if (idx == IDX_PIN_FUNC)
        pin_func_r <= wb_dat_i[7:0] & MASK_PIN_FUNC;
      if (idx == IDX_XCVR_TWO)
        xcvr_two_r <= wb_dat_i[7:0] & MASK_XCVR_TWO;
      if (idx == IDX_CLK_SRC)
        clk_src_r <= wb_dat_i[7:0] & MASK_CLK_SRC;
    end
  end

  // ==========================================================================
  // Interrupt pin
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      interrupt_out_n <= 1'b1;
    else
      interrupt_out_n <= !(irq_pending && !inhibit_r[BIT_PIN_INHIBIT]);
  end

  // ==========================================================================
  // Shared pin functions
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      shared_pins <= '0;
    else
    begin
      if (pin_func_r[BIT_ALARM_SEL])
        shared_pins.shared_alarm_pin <= port_status.rx_sig_freeze;
      else if (xcvr_two_r[BIT_LOSS_SRC])
        shared_pins.shared_alarm_pin <= port_status.rx_loss_line;
      else
        shared_pins.shared_alarm_pin <= port_status.rx_loss_framer;
      shared_pins.rx_sync_pin <= pin_func_r[BIT_SYNC_SEL] ?
        port_status.rx_mframe_sync : port_status.rx_frame_sync;
      shared_pins.tx_channel_pin <= pin_func_r[BIT_TXCH_SEL] ?
        port_status.tx_chan_clock : port_status.tx_chan_block;
      shared_pins.rx_channel_pin <= pin_func_r[BIT_RXCH_SEL] ?
        port_status.rx_chan_clock : port_status.rx_chan_block;
    end
  end

  // ==========================================================================
  // Interleaved bus and backplane clock rate
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      interleaved_bus_mode <= IBUS_OFF;
      interleaved_bus_rate <= 4'h0;
      backplane_clock_rate <= 4'h1;
    end
    else
    begin
      interleaved_bus_mode <= gpc_ibus_mode_t'(pin_func_r[LSB_IBUS_MODE +: 2]);
      interleaved_bus_rate <= (pin_func_r[LSB_IBUS_MODE +: 2] == 2'h0) ? 4'h0 :
                              gpc_multiple(pin_func_r[LSB_IBUS_MODE +: 2]);
      backplane_clock_rate <= gpc_multiple(pin_func_r[LSB_BP_RATE +: 2]);
    end
  end

  // ==========================================================================
  // Frame sync pin
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      frame_cnt_r <= '0;
    else if (frame_cnt_r == FRAME_CNT_W'(FRAME_CYCLES - 1))
      frame_cnt_r <= '0;
    else
      frame_cnt_r <= frame_cnt_r + 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_frame_sync_pin_o  <= 1'b0;
      tx_frame_sync_pin_oe <= 1'b0;
      frame_sync           <= 1'b0;
    end
    else
    begin
      tx_frame_sync_pin_oe <= xcvr_two_r[BIT_FS_DIR];
      tx_frame_sync_pin_o  <= xcvr_two_r[BIT_FS_DIR] &&
                              frame_cnt_r == FRAME_CNT_W'(FRAME_CYCLES - 1);
      frame_sync <= xcvr_two_r[BIT_FS_DIR] ?
        (frame_cnt_r == FRAME_CNT_W'(FRAME_CYCLES - 1)) : tx_frame_sync_pin_i;
    end
  end

  // ==========================================================================
  // Backplane reference and master clock
  assign ref_src       = clk_src_r[LSB_REF_SRC +: 4];
  assign ref_rate      = clk_src_r[BIT_REF_RATE];
  assign ref_from_mclk = (ref_src == REF_SRC_MCLK_T1 && ref_rate) ||
                         (ref_src == REF_SRC_MCLK_E1 && !ref_rate);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      nco_r <= '0;
    else if (ref_from_mclk)
      nco_r <= nco_r + (ref_rate ? NCO_INC_T1 : NCO_INC_E1);
    else
      nco_r <= '0;
  end

  always_comb
  begin
    ref_nxt = 1'b0;
    if (ref_src <= REF_SRC_LAST_CH)
      ref_nxt = recovered_clock[ref_src[2:0]];
    else if (ref_from_mclk)
      ref_nxt = nco_r[NCO_W-1];
    else if (ref_src == REF_SRC_PIN)
      ref_nxt = reference_clock_pin_i;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reference_clock_pin_o  <= 1'b0;
      reference_clock_pin_oe <= 1'b0;
      backplane_ref_clock    <= 1'b0;
      backplane_ref_rate     <= 1'b0;
      ref_config_valid       <= 1'b1;
    end
    else
    begin
      reference_clock_pin_oe <= ref_from_mclk;
      reference_clock_pin_o  <= ref_from_mclk && nco_r[NCO_W-1];
      backplane_ref_clock    <= ref_nxt;
      backplane_ref_rate     <= ref_rate;
      ref_config_valid       <= ref_src <= REF_SRC_LAST_CH || ref_from_mclk ||
                                ref_src == REF_SRC_PIN;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      master_base_rate       <= 1'b0;
      master_period_multiple <= 4'h1;
    end
    else
    begin
      master_base_rate       <= clk_src_r[BIT_MBASE];
      master_period_multiple <= gpc_multiple(clk_src_r[LSB_MMULT +: 2]);
    end
  end

  // ==========================================================================
  // Frame pulse spacing monitor
  logic [FRAME_CNT_W-1:0] fs_gap_r;
  logic                   fs_armed_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fs_gap_r <= '0;
    else if (tx_frame_sync_pin_o)
      fs_gap_r <= '0;
    else
      fs_gap_r <= fs_gap_r + 1'b1;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fs_armed_r <= 1'b0;
    else if (!tx_frame_sync_pin_oe)
      fs_armed_r <= 1'b0;
    else if (tx_frame_sync_pin_o)
      fs_armed_r <= 1'b1;
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_irq_inhibit_high: assert property (inhibit_r[BIT_PIN_INHIBIT] |=> interrupt_out_n)
    else $error("Interrupt pin low while inhibited");
  chk_irq_pending_low: assert property
    (irq_pending && !inhibit_r[BIT_PIN_INHIBIT] |=> !interrupt_out_n)
    else $error("Interrupt pin not low on pending interrupt");
  chk_ibus_rate_map: assert property (##1 interleaved_bus_rate ==
    (($past(pin_func_r[LSB_IBUS_MODE +: 2]) == 2'h0) ? 4'h0 :
     4'h1 << $past(pin_func_r[LSB_IBUS_MODE +: 2])))
    else $error("Interleaved bus rate mismatch");
  chk_bp_rate_map: assert property (##1 backplane_clock_rate ==
    4'h1 << $past(pin_func_r[LSB_BP_RATE +: 2]))
    else $error("Backplane clock rate mismatch");
  chk_alarm_loss_line: assert property (!pin_func_r[BIT_ALARM_SEL] &&
    xcvr_two_r[BIT_LOSS_SRC] |=> shared_pins.shared_alarm_pin ==
    $past(port_status.rx_loss_line))
    else $error("Alarm pins not showing line loss");
  chk_alarm_freeze: assert property (pin_func_r[BIT_ALARM_SEL] |=>
    shared_pins.shared_alarm_pin == $past(port_status.rx_sig_freeze))
    else $error("Alarm pins not showing signaling freeze");
  chk_sync_pulse_gap: assert property
    (tx_frame_sync_pin_o && xcvr_two_r[BIT_FS_DIR] |=> !tx_frame_sync_pin_o [*8])
    else $error("Frame sync pulse wider than one cycle");
  chk_sync_pulse_period: assert property (fs_armed_r && tx_frame_sync_pin_oe |->
    tx_frame_sync_pin_o == (fs_gap_r == FRAME_CNT_W'(FRAME_CYCLES - 1)))
    else $error("Frame sync period not 2500 cycles");
  chk_sync_output_drive: assert property
    (xcvr_two_r[BIT_FS_DIR] |=> tx_frame_sync_pin_oe)
    else $error("Frame sync pin not driven while output");
  chk_sync_input_hiz: assert property (!xcvr_two_r[BIT_FS_DIR] |=> !tx_frame_sync_pin_oe)
    else $error("Frame sync pin driven while input");
  chk_ref_pin_dir: assert property (##1 reference_clock_pin_oe == $past(ref_from_mclk))
    else $error("Reference pin direction wrong");
  chk_ref_pin_input: assert property (ref_src == REF_SRC_PIN |=>
    !reference_clock_pin_oe && backplane_ref_clock == $past(reference_clock_pin_i))
    else $error("Reference pin input not selected");
  chk_ref_channel: assert property (ref_src <= REF_SRC_LAST_CH |=>
    backplane_ref_clock == $past(recovered_clock[ref_src[2:0]]))
    else $error("Recovered clock channel not selected");
  chk_ref_rate_copy: assert property (##1 backplane_ref_rate == $past(ref_rate))
    else $error("Reference rate bit not shown");
  chk_master_base: assert property
    (##1 master_base_rate == $past(clk_src_r[BIT_MBASE]))
    else $error("Master base rate bit not shown");
  chk_master_mult: assert property (##1 master_period_multiple ==
    4'h1 << $past(clk_src_r[LSB_MMULT +: 2]))
    else $error("Master period multiple mismatch");
  chk_bus_ack_one: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack held for two cycles");

  cov_write_func: cover property (wr_go && idx == IDX_PIN_FUNC);
  cov_sync_out: cover property ($rose(tx_frame_sync_pin_oe));
  cov_ref_mclk: cover property (ref_from_mclk && ref_rate);
  cov_irq_inhibit: cover property (irq_pending && inhibit_r[BIT_PIN_INHIBIT]);

endmodule : gpc_global_ctrl

// ==== test/gpc_far_model.sv ====
// Far-side model: recovered line clocks, system frame pulse, external reference
`timescale 1ns/1ps

module gpc_far_model
  import gpc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       ref_rate,
  output logic      [7:0] recovered_clock,
  output logic            fs_drive,
  output logic            ref_drive
);
  // ==========================================================================
  // Recovered clocks, each channel at its own rate
  logic [8:0]  rc_cnt_r;
  logic [11:0] fs_cnt_r;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rc_cnt_r <= 9'h000;
    else
      rc_cnt_r <= rc_cnt_r + 9'h001;
  end

  assign recovered_clock = rc_cnt_r[8:1];

  // ==========================================================================
  // System frame pulse every 125 us
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      fs_cnt_r <= 12'h000;
    else if (fs_cnt_r == 12'(FRAME_CYCLES - 1))
      fs_cnt_r <= 12'h000;
    else
      fs_cnt_r <= fs_cnt_r + 12'h001;
  end

  assign fs_drive = (fs_cnt_r == 12'h000);

  // ==========================================================================
  // External reference, free running at the programmed rate
  initial
  begin
    ref_drive = 1'b0;
    forever
    begin
      #(ref_rate ? 323.834 : 244.141);
      ref_drive = ~ref_drive;
    end
  end

endmodule : gpc_far_model

// ==== test/gpc_global_ctrl_tb.sv ====
// Self-checking bench for the global pin and clock select bank
`timescale 1ns/1ps

module gpc_global_ctrl_tb
  import gpc_pkg::*;
;
  // ==========================================================================
  // Signals
  logic              clk = 1'b0;
  logic              reset_n = 1'b0;
  logic              wb_cyc_i = 1'b0;
  logic              wb_stb_i = 1'b0;
  logic              wb_we_i = 1'b0;
  logic [ADDR_W-1:0] wb_adr_i = '0;
  logic [3:0]        wb_sel_i = 4'h0;
  logic [DATA_W-1:0] wb_dat_i = '0;
  logic [DATA_W-1:0] wb_dat_o;
  logic              wb_ack_o;
  logic              irq_pending = 1'b0;
  logic              interrupt_out_n;
  gpc_port_status_t  port_status = 72'h11_22_33_44_55_66_77_88_99;
  gpc_shared_pins_t  shared_pins;
  gpc_ibus_mode_t    interleaved_bus_mode;
  logic [3:0]        interleaved_bus_rate, backplane_clock_rate, master_period_multiple;
  logic              fs_i, fs_o, fs_oe, frame_sync, fs_drive;
  logic [7:0]        recovered_clock;
  logic              ref_i, ref_o, ref_oe, ref_drive, model_rate = 1'b0;
  logic              backplane_ref_clock, backplane_ref_rate, ref_config_valid;
  logic              master_base_rate;
  int                mismatches = 0;
  int                num_checks = 0;
  logic [9:0]        idx_tab [5] = '{IDX_PIN_INHIBIT, IDX_PIN_FUNC, IDX_XCVR_TWO,
                                     IDX_CLK_SRC, 10'h0F4};
  logic [7:0]        msk_tab [5] = '{MASK_PIN_INHIBIT, MASK_PIN_FUNC, MASK_XCVR_TWO,
                                     MASK_CLK_SRC, 8'h00};
  logic [6:0]        ref_tab [8] = '{7'h47, 7'h4B, 7'h51, 7'h55, 7'h40, 7'h4C, 7'h58, 7'h7C};

  always #25 clk = ~clk;

  // Pins resolve from both parties
  assign fs_i  = fs_oe ? fs_o : fs_drive;
  assign ref_i = ref_oe ? ref_o : ref_drive;

  // ==========================================================================
  // Instances
  gpc_global_ctrl i_gpc_global_ctrl (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_pending(irq_pending),
    .interrupt_out_n(interrupt_out_n), .port_status(port_status), .shared_pins(shared_pins),
    .interleaved_bus_mode(interleaved_bus_mode), .interleaved_bus_rate(interleaved_bus_rate),
    .backplane_clock_rate(backplane_clock_rate), .tx_frame_sync_pin_i(fs_i),
    .tx_frame_sync_pin_o(fs_o), .tx_frame_sync_pin_oe(fs_oe), .frame_sync(frame_sync),
    .recovered_clock(recovered_clock), .reference_clock_pin_i(ref_i),
    .reference_clock_pin_o(ref_o), .reference_clock_pin_oe(ref_oe),
    .backplane_ref_clock(backplane_ref_clock), .backplane_ref_rate(backplane_ref_rate),
    .ref_config_valid(ref_config_valid), .master_base_rate(master_base_rate),
    .master_period_multiple(master_period_multiple));

  gpc_far_model i_gpc_far_model (
    .clk(clk), .reset_n(reset_n), .ref_rate(model_rate), .recovered_clock(recovered_clock),
    .fs_drive(fs_drive), .ref_drive(ref_drive));

  // ==========================================================================
  // Tasks
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task automatic fail_timeout();
    mismatches++;
    stop_test();
  endtask : fail_timeout

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic wb_cycle(input logic we, input logic [9:0] idx, input logic [3:0] sel,
                          input logic [7:0] wdat, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, wdat};
    do
    begin
      @(posedge clk);
      n++;
      if (n > 20)
        fail_timeout();
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_cycle

  task automatic wr(input logic [9:0] idx, input logic [7:0] val);
    logic [31:0] d;
    wb_cycle(1'b1, idx, 4'hF, val, d);
  endtask : wr

  task automatic wait_fs(output int n);
    n = 0;
    do
    begin
      tick(1);
      n++;
      if (n > 3000)
        fail_timeout();
    end while (fs_i !== 1'b1);
  endtask : wait_fs

  // ==========================================================================
  // Main sequence
  initial
  begin
    logic [31:0]      d;
    int               cnt;
    logic [7:0]       rc_prev;
    logic             pin_prev;
    logic [3:0]       c;
    logic             r, eo, ev;
    gpc_shared_pins_t e;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      wb_cycle(1'b0, idx_tab[i], 4'hF, 8'h00, d);
      chk(d, 32'h0);
      wr(idx_tab[i], 8'hFF);
      wb_cycle(1'b0, idx_tab[i], 4'hF, 8'h00, d);
      chk(d, {24'h0, msk_tab[i]});
      wr(idx_tab[i], 8'h00);
    end
    wb_cycle(1'b1, IDX_PIN_FUNC, 4'hE, 8'h55, d);
    wb_cycle(1'b0, IDX_PIN_FUNC, 4'hF, 8'h00, d);
    chk(d, 32'h0);
    // Interrupt pin with and without inhibit
    @(posedge clk);
    irq_pending <= 1'b1;
    tick(2);
    chk(interrupt_out_n, 0);
    wr(IDX_PIN_INHIBIT, 8'h01);
    tick(2);
    chk(interrupt_out_n, 1);
    wr(IDX_PIN_INHIBIT, 8'h00);
    tick(2);
    chk(interrupt_out_n, 0);
    // Bus mode and backplane rate; framer settings kept consistent
    for (int m = 0; m < 4; m++)
    begin
      wr(IDX_PIN_FUNC, {2'(m), 2'(3 - m), 4'h0});
      tick(2);
      chk(32'(interleaved_bus_mode), m);
      chk(interleaved_bus_rate, (m == 0) ? 0 : (1 << m));
      chk(backplane_clock_rate, 1 << (3 - m));
    end
    // Shared pin functions
    for (int s = 0; s < 32; s++)
    begin
      @(posedge clk);
      port_status <= {port_status[63:0], port_status[71:64]};
      wr(IDX_PIN_FUNC, {4'h0, 4'(s)});
      wr(IDX_XCVR_TWO, {5'h00, s[4], 2'b00});
      tick(2);
      e.shared_alarm_pin = s[3] ? port_status.rx_sig_freeze :
                           (s[4] ? port_status.rx_loss_line : port_status.rx_loss_framer);
      e.rx_sync_pin    = s[2] ? port_status.rx_mframe_sync : port_status.rx_frame_sync;
      e.tx_channel_pin = s[1] ? port_status.tx_chan_clock : port_status.tx_chan_block;
      e.rx_channel_pin = s[0] ? port_status.rx_chan_clock : port_status.rx_chan_block;
      chk(shared_pins, e);
    end
    // Frame sync pin as output then input
    wr(IDX_XCVR_TWO, 8'h02);
    wait_fs(cnt);
    chk(fs_oe, 1);
    chk(frame_sync, 1);
    wait_fs(cnt);
    chk(cnt, 2500);
    wr(IDX_XCVR_TWO, 8'h00);
    tick(2);
    chk(fs_oe, 0);
    wait_fs(cnt);
    tick(1);
    chk(frame_sync, 1);
    tick(1);
    chk(frame_sync, 0);
    // Recovered clock references
    for (int k = 0; k < 16; k++)
    begin
      wr(IDX_CLK_SRC, {4'(k / 2), 1'(k), 3'b000});
      tick(2);
      chk(backplane_ref_rate, k % 2);
      chk(ref_config_valid, 1);
      repeat (4)
      begin
        @(posedge clk);
        rc_prev = recovered_clock;
        #1;
        chk(backplane_ref_clock, rc_prev[k / 2]);
      end
    end
    // Derived, external and illegal reference codes
    for (int k = 0; k < 8; k++)
    begin
      {c, r, eo, ev} = ref_tab[k];
      model_rate = r; // Source rate follows the programmed rate
      wr(IDX_CLK_SRC, {c, r, 3'b000});
      tick(2);
      chk(ref_oe, eo);
      chk(ref_config_valid, ev);
      cnt = 0;
      pin_prev = ref_o;
      repeat (eo ? 1000 : 0)
      begin
        tick(1);
        cnt += (ref_o && !pin_prev) ? 1 : 0;
        pin_prev = ref_o;
      end
      if (eo)
        chk(cnt >= (r ? 77 : 102) && cnt <= (r ? 78 : 103), 1);
      repeat (eo ? 0 : 4)
      begin
        @(posedge clk);
        pin_prev = ref_i;
        #1;
        chk(backplane_ref_clock, ev & pin_prev);
      end
    end
    // Master clock family and multiple
    for (int v = 0; v < 8; v++)
    begin
      wr(IDX_CLK_SRC, {5'h00, 3'(v)});
      tick(2);
      chk(master_base_rate, v / 4);
      chk(master_period_multiple, 1 << (v % 4));
    end
    stop_test();
  end

endmodule : gpc_global_ctrl_tb
